// File: ccvr_defs.svh
`ifndef CCVR_DEFS_SVH
`define CCVR_DEFS_SVH

// Register indices on the serial link.
`define CCVR_IDX_FCC 8'h02
`define CCVR_IDX_PTC 8'h03
`define CCVR_IDX_CVC 8'h04

// Reset values.
`define CCVR_RST_FCC 8'h60
`define CCVR_RST_PTC 8'h11
`define CCVR_RST_CVC 8'hb2

// Seven-bit serial device address; the value is arbitrary.
`define CCVR_DEV_ADDR 7'h55

// Bits in one serial byte, and the index of its last shifted bit.
`define CCVR_BYTE_BITS 4'h8
`define CCVR_LAST_BIT 4'h7

// Decoded figures, in mA, mV or percent of the regulator rail.
`define CCVR_FCC_BASE 13'h200
`define CCVR_FCC_STEP 13'h040
`define CCVR_PRE_STEP 13'h080
`define CCVR_TERM_BASE 13'h080
`define CCVR_TERM_STEP 13'h080
`define CCVR_CHARGE_VOLTAGE_CODE_BASE 13'h0db0
`define CCVR_CHARGE_VOLTAGE_CODE_STEP 13'h010
`define CCVR_EXIT_LOW 13'h0af0
`define CCVR_EXIT_HIGH 13'h0bb8
`define CCVR_RECH_LOW 13'h0064
`define CCVR_RECH_HIGH 13'h012c
`define CCVR_COLD_LOW 7'h4c
`define CCVR_COLD_HIGH 7'h4f

// Divisors for the reduced-current option: 20% and 50%.
`define CCVR_FCC_DIV 13'h005
`define CCVR_PRE_DIV 13'h002

`endif

// File: ccvr_host_model.sv
module ccvr_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // Cycles per quarter bit; a larger value gives a slower host.
    int ph = 3;

    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic hw(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Also serves as a repeated start when the clock is low.
    task automatic start_cond();
        sda_pull <= 1'b0;
        hw(ph);
        scl <= 1'b1;
        hw(2 * ph);
        sda_pull <= 1'b1;
        hw(ph);
        scl <= 1'b0;
        hw(ph);
    endtask

    task automatic stop_cond();
        sda_pull <= 1'b1;
        hw(ph);
        scl <= 1'b1;
        hw(2 * ph);
        sda_pull <= 1'b0;
        hw(2 * ph);
    endtask

    task automatic bit_io(input logic b, output logic r);
        sda_pull <= ~b;
        hw(ph);
        scl <= 1'b1;
        hw(ph);
        r = sda_line;
        hw(ph);
        scl <= 1'b0;
        hw(ph);
    endtask

    task automatic byte_out(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = (r === 1'b0);
    endtask

    task automatic byte_in(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(~more, r);
    endtask

    task automatic write_regs(input logic [6:0] dev, input logic [7:0] idx,
        input logic [7:0] d [3], input int n, output logic ok);
        logic a;
        start_cond();
        byte_out({dev, 1'b0}, ok);
        if (ok)
        begin
            byte_out(idx, a);
            ok = ok & a;
            for (int i = 0; i < n; i++)
            begin
                byte_out(d[i], a);
                ok = ok & a;
            end
        end
        stop_cond();
    endtask

    task automatic read_regs(input logic [7:0] idx, input int n,
        output logic [7:0] q [3], output logic ok);
        logic a;
        start_cond();
        byte_out(8'haa, ok);
        byte_out(idx, a);
        ok = ok & a;
        start_cond();
        byte_out(8'hab, a);
        ok = ok & a;
        for (int i = 0; i < n; i++)
            byte_in(i < n - 1, q[i]);
        stop_cond();
    endtask
endmodule // ccvr_host_model

// File: ccvr_i2c_link.sv
`include "ccvr_defs.svh"

module ccvr_i2c_link (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic link_rst_n,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Register exchange with the system domain
    output ccvr_pkg::ccvr_req_s req,
    output logic req_tgl,
    input wire logic ack_tgl,
    input wire logic [7:0] rd_data
);

    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] ack_s;
    logic scl_q;
    logic sda_q;
    logic ack_q;
    ccvr_pkg::ccvr_lnk_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [1:0] phase;
    logic rd_mode;
    logic mack;
    logic [7:0] ptr;
    logic [7:0] rdbuf;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic byte_done;
    logic addr_hit;

    always_ff @(posedge link_clk)
    begin
        scl_s <= {scl_s[0], scl_in};
        sda_s <= {sda_s[0], sda_in};
        ack_s <= {ack_s[0], ack_tgl};
        scl_q <= scl_s[1];
        sda_q <= sda_s[1];
        ack_q <= ack_s[1];
    end

    assign scl_rise = scl_s[1] & ~scl_q;
    assign scl_fall = ~scl_s[1] & scl_q;
    assign start = scl_s[1] & scl_q & sda_q & ~sda_s[1];
    assign stop = scl_s[1] & scl_q & ~sda_q & sda_s[1];
    assign byte_done = (state == ccvr_pkg::LNK_RX) && scl_fall
        && (bit_cnt == `CCVR_BYTE_BITS);
    assign addr_hit = (shreg[7:1] == `CCVR_DEV_ADDR);

    // Byte framing, acknowledge and transmit sequencing.
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            state <= ccvr_pkg::LNK_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            phase <= 2'h0;
            rd_mode <= 1'b0;
            mack <= 1'b0;
        end
        else if (start)
        begin
            state <= ccvr_pkg::LNK_RX;
            bit_cnt <= 4'h0;
            phase <= 2'h0;
        end
        else if (stop)
            state <= ccvr_pkg::LNK_IDLE;
        else
        begin
            unique case (state)
                ccvr_pkg::LNK_IDLE:
                    state <= ccvr_pkg::LNK_IDLE;
                ccvr_pkg::LNK_RX:
                    if (scl_rise)
                    begin
                        shreg <= {shreg[6:0], sda_s[1]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        bit_cnt <= 4'h0;
                        if (phase != 2'h0 || addr_hit)
                            state <= ccvr_pkg::LNK_ACK;
                        else
                            state <= ccvr_pkg::LNK_IDLE;
                        if (phase == 2'h0)
                            rd_mode <= shreg[0];
                    end
                ccvr_pkg::LNK_ACK:
                    if (scl_fall)
                    begin
                        if (rd_mode)
                        begin
                            state <= ccvr_pkg::LNK_TX;
                            shreg <= rdbuf;
                        end
                        else
                        begin
                            state <= ccvr_pkg::LNK_RX;
                            phase <= (phase == 2'h0) ? 2'h1 : 2'h2;
                        end
                    end
                ccvr_pkg::LNK_TX:
                    if (scl_fall)
                    begin
                        if (bit_cnt == `CCVR_LAST_BIT)
                        begin
                            state <= ccvr_pkg::LNK_TACK;
                            bit_cnt <= 4'h0;
                        end
                        else
                        begin
                            shreg <= {shreg[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                ccvr_pkg::LNK_TACK:
                    if (scl_rise)
                        mack <= ~sda_s[1];
                    else if (scl_fall)
                    begin
                        state <= mack ? ccvr_pkg::LNK_TX
                            : ccvr_pkg::LNK_IDLE;
                        shreg <= rdbuf;
                    end
            endcase
        end
    end

    // Register pointer and requests to the system domain.
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            ptr <= 8'h00;
            req <= '0;
            req_tgl <= 1'b0;
        end
        else if (byte_done && phase == 2'h1)
            ptr <= shreg;
        else if ((byte_done && phase == 2'h2)
            || (byte_done && phase == 2'h0 && addr_hit && shreg[0])
            || (state == ccvr_pkg::LNK_TX && scl_fall
            && bit_cnt == `CCVR_LAST_BIT))
        begin
            req.wr <= (phase == 2'h2) && (state == ccvr_pkg::LNK_RX);
            req.idx <= ptr;
            req.data <= shreg;
            req_tgl <= ~req_tgl;
            ptr <= ptr + 8'h01;
        end
    end

    // Read data are stable once the returned toggle is seen.
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
            rdbuf <= 8'h00;
        else if (ack_s[1] ^ ack_q)
            rdbuf <= rd_data;
    end

    assign sda_out = 1'b0;
    assign sda_oe = (state == ccvr_pkg::LNK_ACK)
        || (state == ccvr_pkg::LNK_TX && !shreg[7]);

endmodule // ccvr_i2c_link

// File: ccvr_pkg.sv
package ccvr_pkg;

    typedef struct packed {
        logic [5:0] fast_charge_current_code;
        logic cold_threshold_select;
        logic reduced_current_force;
    } ccvr_fcc_s;

    typedef struct packed {
        logic [3:0] precharge_current_code;
        logic reserved_bit;
        logic [2:0] termination_current_code;
    } ccvr_ptc_s;

    typedef struct packed {
        logic [5:0] charge_voltage_code;
        logic precharge_exit_threshold_select;
        logic recharge_offset_select;
    } ccvr_cvc_s;

    // Values handed to the charger control loops.
    typedef struct packed {
        logic [12:0] fast_charge_ma;
        logic [12:0] precharge_current_value;
        logic [12:0] termination_ma;
        logic [12:0] charge_voltage_mv;
        logic [12:0] precharge_exit_mv;
        logic [12:0] recharge_offset_mv;
        logic [6:0] cold_threshold_pct;
    } ccvr_cfg_s;

    // One register access passed from the link domain.
    typedef struct packed {
        logic wr;
        logic [7:0] idx;
        logic [7:0] data;
    } ccvr_req_s;

    typedef enum logic [2:0] {
        LNK_IDLE,
        LNK_RX,
        LNK_ACK,
        LNK_TX,
        LNK_TACK
    } ccvr_lnk_e;

endpackage

// File: ccvr_regs.sv
// Notes on behaviour
// R1: Six-bit fast-charge code, 64 mA steps above 512.
// R2: Bit one picks boost cold threshold, 76 or 79%.
// R3: Force bit gives 20% fast, 50% pre-charge.
// R4: Pre-charge code, 128 mA steps, zero equals one.
// R5: Termination code, 128 mA steps above 128.
// R6: Pre-charge/termination resets 0x11, reserved bit writable.
// R7: Voltage register holds code, exit and offset selects.
// R8: Charge voltage is 3.504 V plus 16 mV steps.
// R9: Exit select picks 2.8 V or 3.0 V.
// R10: Offset select picks 100 mV or 300 mV.
// R11: Host writes zero reserved bits, limits fast code.
`include "ccvr_defs.svh"

module ccvr_regs (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial link
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Stored registers
    output ccvr_pkg::ccvr_fcc_s fcc_ctrl,
    output ccvr_pkg::ccvr_ptc_s ptc_ctrl,
    output ccvr_pkg::ccvr_cvc_s cvc_ctrl,
    // Decoded settings for the control loops
    output ccvr_pkg::ccvr_cfg_s cfg
);

    logic [1:0] link_rst_s;
    ccvr_pkg::ccvr_req_s req;
    logic req_tgl;
    logic [1:0] req_s;
    logic req_q;
    logic fire;
    logic ack_tgl;
    logic [7:0] rd_word;

    function automatic logic [12:0] fast_ma(input ccvr_pkg::ccvr_fcc_s r);
        logic [12:0] v;
        v = `CCVR_FCC_BASE
            + 13'(r.fast_charge_current_code) * `CCVR_FCC_STEP;
        return r.reduced_current_force ? v / `CCVR_FCC_DIV : v;
    endfunction

    function automatic logic [12:0] pre_ma(input ccvr_pkg::ccvr_ptc_s p,
        input logic reduce);
        logic [12:0] v;
        v = (p.precharge_current_code == 4'h0) ? `CCVR_PRE_STEP
            : 13'(p.precharge_current_code) * `CCVR_PRE_STEP;
        return reduce ? v / `CCVR_PRE_DIV : v;
    endfunction

    function automatic logic [12:0] term_ma(input ccvr_pkg::ccvr_ptc_s p);
        return `CCVR_TERM_BASE
            + 13'(p.termination_current_code) * `CCVR_TERM_STEP;
    endfunction

    function automatic logic [12:0] volt_mv(input ccvr_pkg::ccvr_cvc_s c);
        return `CCVR_CHARGE_VOLTAGE_CODE_BASE
            + 13'(c.charge_voltage_code) * `CCVR_CHARGE_VOLTAGE_CODE_STEP;
    endfunction

    // Link-side reset follows rst_n through two link-clock stages.
    always_ff @(posedge link_clk)
    begin
        link_rst_s <= {link_rst_s[0], rst_n};
    end

    ccvr_i2c_link u_link (
        .link_clk(link_clk),
        .link_rst_n(link_rst_s[1]),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .req(req),
        .req_tgl(req_tgl),
        .ack_tgl(ack_tgl),
        .rd_data(rd_word)
    );

    // Request toggle crossing; the request word is held until answered.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            req_s <= 2'h0;
            req_q <= 1'b0;
        end
        else
        begin
            req_s <= {req_s[0], req_tgl};
            req_q <= req_s[1];
        end
    end

    assign fire = req_s[1] ^ req_q;

    // Register writes; every bit, the reserved one included, is stored.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            fcc_ctrl <= `CCVR_RST_FCC; // see R1
            ptc_ctrl <= `CCVR_RST_PTC; // see R6
            cvc_ctrl <= `CCVR_RST_CVC; // see R7
        end
        else if (fire && req.wr)
        begin
            if (req.idx == `CCVR_IDX_FCC)
                fcc_ctrl <= req.data; // see R1
            if (req.idx == `CCVR_IDX_PTC)
                ptc_ctrl <= req.data; // see R6
            if (req.idx == `CCVR_IDX_CVC)
                cvc_ctrl <= req.data; // see R7
        end
    end

    // Every request is answered; unmapped indices read as zero.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rd_word <= 8'h00;
            ack_tgl <= 1'b0;
        end
        else if (fire)
        begin
            ack_tgl <= ~ack_tgl;
            if (req.idx == `CCVR_IDX_FCC)
                rd_word <= fcc_ctrl;
            else if (req.idx == `CCVR_IDX_PTC)
                rd_word <= ptc_ctrl;
            else if (req.idx == `CCVR_IDX_CVC)
                rd_word <= cvc_ctrl;
            else
                rd_word <= 8'h00;
        end
    end

    // Decoded settings, one cycle behind the registers.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            cfg <= '0;
        else
        begin
            cfg.fast_charge_ma <= fast_ma(fcc_ctrl); // see R1, R3
            cfg.precharge_current_value <=
                pre_ma(ptc_ctrl, fcc_ctrl.reduced_current_force); // see R4
            cfg.termination_ma <= term_ma(ptc_ctrl); // see R5
            cfg.charge_voltage_mv <= volt_mv(cvc_ctrl); // see R8
            cfg.precharge_exit_mv <=
                cvc_ctrl.precharge_exit_threshold_select
                ? `CCVR_EXIT_HIGH : `CCVR_EXIT_LOW; // see R9
            cfg.recharge_offset_mv <= cvc_ctrl.recharge_offset_select
                ? `CCVR_RECH_HIGH : `CCVR_RECH_LOW; // see R10
            cfg.cold_threshold_pct <= fcc_ctrl.cold_threshold_select
                ? `CCVR_COLD_HIGH : `CCVR_COLD_LOW; // see R2
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    reset_values_a: assert property ( // see R6
        $rose(rst_n) |-> fcc_ctrl == `CCVR_RST_FCC
            && ptc_ctrl == `CCVR_RST_PTC && cvc_ctrl == `CCVR_RST_CVC)
        else $error("Registers not at reset values.");

    fast_write_a: assert property ( // see R1, R3
        fire && req.wr && req.idx == `CCVR_IDX_FCC |=> ##1
            cfg.fast_charge_ma == ($past(req.data[0], 2)
            ? (`CCVR_FCC_BASE + 13'($past(req.data[7:2], 2))
            * `CCVR_FCC_STEP) / `CCVR_FCC_DIV
            : `CCVR_FCC_BASE + 13'($past(req.data[7:2], 2))
            * `CCVR_FCC_STEP))
        else $error("Fast-charge current not decoded from write.");

    reduced_force_a: assert property ( // see R3
        fcc_ctrl.reduced_current_force && $stable(fcc_ctrl)
            && $stable(ptc_ctrl) |=>
            cfg.fast_charge_ma * `CCVR_FCC_DIV
            <= `CCVR_FCC_BASE + 13'($past(fcc_ctrl.fast_charge_current_code))
            * `CCVR_FCC_STEP
            && cfg.precharge_current_value
            == pre_ma($past(ptc_ctrl), 1'b0) / `CCVR_PRE_DIV)
        else $error("Reduced current not applied.");

    pre_floor_a: assert property ( // see R4
        ptc_ctrl.precharge_current_code <= 4'h1
            && !fcc_ctrl.reduced_current_force |=>
            cfg.precharge_current_value == `CCVR_PRE_STEP)
        else $error("Lowest pre-charge codes not 128 mA.");

    term_write_a: assert property ( // see R5
        fire && req.wr && req.idx == `CCVR_IDX_PTC |=> ##1
            cfg.termination_ma == `CCVR_TERM_BASE
            + 13'($past(req.data[2:0], 2)) * `CCVR_TERM_STEP)
        else $error("Termination current not decoded.");

    reserved_keep_a: assert property ( // see R6
        fire && req.wr && req.idx == `CCVR_IDX_PTC |=>
            ptc_ctrl.reserved_bit == $past(req.data[3]))
        else $error("Reserved bit not stored.");

    voltage_step_a: assert property ( // see R8
        ##1 $changed(cvc_ctrl.charge_voltage_code) |=>
            cfg.charge_voltage_mv - $past(cfg.charge_voltage_mv)
            == (13'($past(cvc_ctrl.charge_voltage_code))
            - 13'($past(cvc_ctrl.charge_voltage_code, 2)))
            * `CCVR_CHARGE_VOLTAGE_CODE_STEP)
        else $error("Charge voltage step is not 16 mV.");

    exit_select_a: assert property ( // see R9
        cvc_ctrl.precharge_exit_threshold_select [*2] |->
            cfg.precharge_exit_mv == `CCVR_EXIT_HIGH)
        else $error("Exit threshold not 3.0 V.");

    offset_select_a: assert property ( // see R10
        !cvc_ctrl.recharge_offset_select [*2] |->
            cfg.recharge_offset_mv == `CCVR_RECH_LOW)
        else $error("Recharge offset not 100 mV.");

    cold_select_a: assert property ( // see R2
        fire && req.wr && req.idx == `CCVR_IDX_FCC && req.data[1] |=> ##1
            cfg.cold_threshold_pct == `CCVR_COLD_HIGH)
        else $error("Cold threshold not 79 percent.");

    voltage_write_a: assert property ( // see R7
        fire && req.wr && req.idx == `CCVR_IDX_CVC |=>
            cvc_ctrl == $past(req.data))
        else $error("Charge-voltage register not written.");

    read_answer_a: assert property (
        fire && !req.wr && req.idx == `CCVR_IDX_CVC |=>
            rd_word == $past(cvc_ctrl) && ack_tgl != $past(ack_tgl))
        else $error("Read not answered with register value.");

    fast_write_c: cover property (fire && req.wr
        && req.idx == `CCVR_IDX_FCC);
    force_on_c: cover property (fcc_ctrl.reduced_current_force);
    volt_read_c: cover property (fire && !req.wr
        && req.idx == `CCVR_IDX_CVC);
    unmapped_c: cover property (fire && req.idx > `CCVR_IDX_CVC);

endmodule // ccvr_regs

// File: test_charge_current_voltage_regs.sv
`define CHK(g, e) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            errors++; \
            $display("unexpected t=%0t got %h exp %h", $time, g, e); \
        end \
    end

module test_charge_current_voltage_regs;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk;
    logic link_clk;
    logic rst_n;
    logic scl;
    logic sda_pull;
    logic sda_line;
    logic sda_out;
    logic sda_oe;
    ccvr_pkg::ccvr_fcc_s fcc_ctrl;
    ccvr_pkg::ccvr_ptc_s ptc_ctrl;
    ccvr_pkg::ccvr_cvc_s cvc_ctrl;
    ccvr_pkg::ccvr_cfg_s cfg;
    int errors = 0;
    int n_checks = 0;
    logic ok;
    logic [7:0] d [3];
    logic [7:0] q [3];

    // Pulled-up data line, low while either party pulls it.
    assign sda_line = (sda_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial
    begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = ~link_clk;
    end

    ccvr_regs dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .fcc_ctrl(fcc_ctrl), .ptc_ctrl(ptc_ctrl), .cvc_ctrl(cvc_ctrl),
        .cfg(cfg));

    ccvr_host_model host_u (.clk(sys_clk), .scl(scl), .sda_pull(sda_pull),
        .sda_line(sda_line));

    function automatic ccvr_pkg::ccvr_cfg_s exp_cfg(input logic [7:0] f,
        input logic [7:0] p, input logic [7:0] v);
        ccvr_pkg::ccvr_cfg_s c;
        int fast;
        int pre;
        fast = 32'h200 + 32'h40 * f[7:2];
        pre = (p[7:4] == 4'h0) ? 32'h80 : 32'h80 * p[7:4];
        if (f[0])
        begin
            fast = fast / 32'h5;
            pre = pre / 32'h2;
        end
        c.fast_charge_ma = 13'(fast);
        c.precharge_current_value = 13'(pre);
        c.termination_ma = 13'(32'h80 + 32'h80 * p[2:0]);
        c.charge_voltage_mv = 13'(32'hdb0 + 32'h10 * v[7:2]);
        c.precharge_exit_mv = v[1] ? 13'h0bb8 : 13'h0af0;
        c.recharge_offset_mv = v[0] ? 13'h012c : 13'h0064;
        c.cold_threshold_pct = f[1] ? 7'h4f : 7'h4c;
        return c;
    endfunction

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(cfg, '0)
        @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic check_regs(input logic [7:0] f, input logic [7:0] p,
        input logic [7:0] v);
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(fcc_ctrl, f)
        `CHK(ptc_ctrl, p)
        `CHK(cvc_ctrl, v)
        `CHK(cfg, exp_cfg(f, p, v))
    endtask

    task automatic read_chk(input logic [7:0] idx, input int n,
        input logic [7:0] e [3]);
        host_u.read_regs(idx, n, q, ok);
        `CHK(ok, 1'b1)
        for (int i = 0; i < n; i++)
            `CHK(q[i], e[i])
    endtask

    task automatic write_chk(input logic [7:0] idx, input int n);
        host_u.write_regs(7'h55, idx, d, n, ok);
        `CHK(ok, 1'b1)
    endtask

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        print_verdict();
    end

    initial
    begin
        rst_n = 1'b0;
        do_reset();
        check_regs(8'h60, 8'h11, 8'hb2);
        read_chk(8'h02, 3, '{8'h60, 8'h11, 8'hb2});
        d = '{8'h9e, 8'hf0, 8'h01};
        write_chk(8'h02, 3);
        check_regs(8'h9e, 8'hf0, 8'h01);
        read_chk(8'h02, 3, '{8'h9e, 8'hf0, 8'h01});
        host_u.ph = 5;
        d = '{8'h01, 8'h07, 8'h00};
        write_chk(8'h02, 2);
        host_u.ph = 3;
        check_regs(8'h01, 8'h07, 8'h01);
        d = '{8'h20, 8'he2, 8'h00};
        write_chk(8'h03, 2);
        check_regs(8'h01, 8'h20, 8'he2);
        host_u.write_regs(7'h2a, 8'h02, d, 1, ok);
        `CHK(ok, 1'b0)
        d = '{8'hff, 8'hff, 8'hff};
        write_chk(8'h05, 1);
        check_regs(8'h01, 8'h20, 8'he2);
        read_chk(8'h01, 2, '{8'h00, 8'h01, 8'h00});
        do_reset();
        check_regs(8'h60, 8'h11, 8'hb2);
        print_verdict();
    end
endmodule // test_charge_current_voltage_regs
